//--- spv_pkg.sv
// package for the port vlan, priority map, station address and time-sync register bank
package spv_pkg;

  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] OFS_VLAN = 8'h00;
  localparam logic [7:0] OFS_TXMAP = 8'h04;
  localparam logic [7:0] OFS_SA_LO = 8'h08;
  localparam logic [7:0] OFS_SA_HI = 8'h0c;
  localparam logic [7:0] OFS_TS_CTL = 8'h10;
  localparam logic [7:0] OFS_TS_ETYPE = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam int ADDR_W = 8;

  // writable bit masks; everything outside reads as zero
  localparam logic [31:0] VLAN_MASK = 32'h0000_ffff;
  localparam logic [31:0] TXMAP_MASK = 32'h7777_7777;
  localparam logic [31:0] SA_LO_MASK = 32'h0000_ffff;
  localparam logic [31:0] SA_HI_MASK = 32'hffff_ffff;
  localparam logic [31:0] CTL_MASK_V1 = 32'hffff_0077;
  localparam logic [31:0] CTL_MASK_V2 = 32'hffff_07ff;
  localparam logic [31:0] ETYPE_MASK = 32'hffff_ffff;
  localparam logic [31:0] MODE_MASK = 32'h0000_0001;

  // reset values
  localparam logic [31:0] VLAN_RST = 32'h0000_0000;
  localparam logic [31:0] TXMAP_RST = 32'h3322_1001;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  // vlan register fields
  localparam int VLAN_PRI_LSB = 13;
  localparam int VLAN_CFI_BIT = 12;
  localparam int VLAN_VID_LSB = 0;
  // priority map: field n at bits 4n+2..4n
  localparam int MAP_STRIDE = 4;

  // time-sync control bits, common
  localparam int CTL_MSG_LSB = 16;
  // first variant
  localparam int V1_TX_VLAN2 = 6;
  localparam int V1_TX_VLAN1 = 5;
  localparam int V1_TX_EN = 4;
  localparam int V1_RX_VLAN2 = 2;
  localparam int V1_RX_VLAN1 = 1;
  localparam int V1_RX_EN = 0;
  // second variant
  localparam int V2_TX_IPV6 = 10;
  localparam int V2_RX_IPV6 = 9;
  localparam int V2_ETYPE2 = 8;
  localparam int V2_TX_IPV4 = 6;
  localparam int V2_TX_VLAN1 = 5;
  localparam int V2_TX_RAW = 4;
  localparam int V2_RX_IPV4 = 3;
  localparam int V2_RX_VLAN2 = 2;
  localparam int V2_RX_VLAN1 = 1;
  localparam int V2_RX_RAW = 0;

  // frame encapsulation seen by the time-sync detector
  typedef enum logic [4:0] {
    SPV_ENC_RAW = 5'b00001,
    SPV_ENC_VLAN1 = 5'b00010,
    SPV_ENC_VLAN2 = 5'b00100,
    SPV_ENC_IPV4 = 5'b01000,
    SPV_ENC_IPV6 = 5'b10000
  } spv_encap_t;

  // one time-sync candidate frame from the port datapath
  typedef struct packed {
    logic valid;
    logic is_tx;
    spv_encap_t encap;
    logic [15:0] ethertype;
    logic [3:0] msg_type;
  } spv_frame_t;

  // port default vlan tag as driven to the datapath
  typedef struct packed {
    logic [2:0] port_default_priority;
    logic port_default_canonical_bit;
    logic [11:0] port_default_vlan_id;
  } spv_vlan_t;

endpackage : spv_pkg

//--- spv_regs.sv
// ahb-lite register bank with priority remap and time-sync acceptance for one switch port
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
module spv_regs (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready out
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [2:0] tx_hdr_prio, // transmit header priority
  input wire logic tx_hdr_valid, // header priority strobe
  output logic [1:0] tx_queue_prio, // mapped switch queue
  output logic tx_queue_valid, // mapped queue strobe
  input spv_pkg::spv_frame_t ts_frame, // time-sync candidate
  output logic ts_result_valid, // result strobe
  output logic ts_accept, // frame is a recognised time-sync message
  output spv_pkg::spv_vlan_t port_vlan, // default vlan tag
  output logic [47:0] station_addr // mac source address, byte 0 in bits 7-0
);

  localparam int ADDR_W_L = spv_pkg::ADDR_W;

  logic [31:0] vlan_q;
  logic [31:0] txmap_q;
  logic [31:0] sa_lo_q;
  logic [31:0] sa_hi_q;
  logic [31:0] ctl_q;
  logic [31:0] etype_q;
  logic [31:0] mode_q;
  logic [ADDR_W_L-1:0] addr_q;
  logic wr_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic [2:0] txq_q;
  logic txv_q;
  logic tsv_q;
  logic tsa_q;

  // queue lookup in the transmit priority map
  function automatic logic [2:0] map_lookup(input logic [31:0] map, input logic [2:0] prio);
    logic [4:0] lsb;
    lsb = {prio, 2'b00};
    map_lookup = 3'(map >> lsb);
  endfunction : map_lookup

  // write merge under a writable mask
  function automatic logic [31:0] masked(input logic [31:0] d, input logic [31:0] m);
    masked = d & m;
  endfunction : masked

  // time-sync acceptance decision for one frame
  function automatic logic ts_decide(input logic [31:0] ctl, input logic v2,
                                     input logic [31:0] et, input spv_pkg::spv_frame_t f);
    logic type_ok;
    logic et_ok;
    logic enc_ok;
    logic tx;
    type_ok = ctl[spv_pkg::CTL_MSG_LSB + int'(f.msg_type)];
    tx = f.is_tx;
    et_ok = (f.ethertype == et[15:0]);
    enc_ok = 1'b0;
    if (!v2) begin
      if (tx ? ctl[spv_pkg::V1_TX_EN] : ctl[spv_pkg::V1_RX_EN]) begin
        case (f.encap)
          spv_pkg::SPV_ENC_RAW: enc_ok = et_ok;
          spv_pkg::SPV_ENC_VLAN1: begin
            enc_ok = et_ok & (tx ? ctl[spv_pkg::V1_TX_VLAN1] : ctl[spv_pkg::V1_RX_VLAN1]);
          end
          spv_pkg::SPV_ENC_VLAN2: begin
            enc_ok = et_ok & (tx ? ctl[spv_pkg::V1_TX_VLAN2] : ctl[spv_pkg::V1_RX_VLAN2]);
          end
          default: enc_ok = 1'b0;
        endcase
      end
    end else begin
      et_ok = et_ok | (ctl[spv_pkg::V2_ETYPE2] & (f.ethertype == et[31:16]));
      case (f.encap)
        spv_pkg::SPV_ENC_RAW: begin
          enc_ok = et_ok & (tx ? ctl[spv_pkg::V2_TX_RAW] : ctl[spv_pkg::V2_RX_RAW]);
        end
        spv_pkg::SPV_ENC_VLAN1: begin
          enc_ok = et_ok & (tx ? ctl[spv_pkg::V2_TX_VLAN1] : ctl[spv_pkg::V2_RX_VLAN1]);
        end
        spv_pkg::SPV_ENC_VLAN2: enc_ok = et_ok & ~tx & ctl[spv_pkg::V2_RX_VLAN2];
        spv_pkg::SPV_ENC_IPV4: begin
          enc_ok = tx ? ctl[spv_pkg::V2_TX_IPV4] : ctl[spv_pkg::V2_RX_IPV4];
        end
        spv_pkg::SPV_ENC_IPV6: begin
          enc_ok = tx ? ctl[spv_pkg::V2_TX_IPV6] : ctl[spv_pkg::V2_RX_IPV6];
        end
        default: enc_ok = 1'b0;
      endcase
    end
    ts_decide = type_ok & enc_ok;
  endfunction : ts_decide

  // address phase decode
  wire logic addr_ok = hsel & htrans[1] & hready;
  wire logic take_wr = addr_ok & hwrite;
  wire logic take_rd = addr_ok & ~hwrite;

  // variant select and the control view shared by read-back and decision
  wire logic variant_two = mode_q[0];
  wire logic [31:0] ctl_mask = variant_two ? spv_pkg::CTL_MASK_V2 : spv_pkg::CTL_MASK_V1;
  wire logic [31:0] ctl_rd = masked(ctl_q, ctl_mask);

  // data phase write strobes
  wire logic wr_vlan = wr_q & (addr_q == spv_pkg::OFS_VLAN);
  wire logic wr_txmap = wr_q & (addr_q == spv_pkg::OFS_TXMAP);
  wire logic wr_sa_lo = wr_q & (addr_q == spv_pkg::OFS_SA_LO);
  wire logic wr_sa_hi = wr_q & (addr_q == spv_pkg::OFS_SA_HI);
  wire logic wr_ctl = wr_q & (addr_q == spv_pkg::OFS_TS_CTL);
  wire logic wr_etype = wr_q & (addr_q == spv_pkg::OFS_TS_ETYPE);
  wire logic wr_mode = wr_q & (addr_q == spv_pkg::OFS_MODE);

  // read selection; unmapped offsets read zero
  wire logic [31:0] rd_mux =
    (addr_q == spv_pkg::OFS_VLAN) ? vlan_q :
    (addr_q == spv_pkg::OFS_TXMAP) ? txmap_q :
    (addr_q == spv_pkg::OFS_SA_LO) ? sa_lo_q :
    (addr_q == spv_pkg::OFS_SA_HI) ? sa_hi_q :
    (addr_q == spv_pkg::OFS_TS_CTL) ? ctl_rd :
    (addr_q == spv_pkg::OFS_TS_ETYPE) ? etype_q :
    (addr_q == spv_pkg::OFS_MODE) ? mode_q : spv_pkg::ZERO_RST;

  // bus response: reads take one wait state so hrdata comes from a flop
  assign hreadyout = ~rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // address phase capture; the offset is held through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
    end else if (addr_ok) begin
      addr_q <= haddr[ADDR_W_L-1:0];
    end
  end

  // data phase markers for the transfer just taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end else begin
      wr_q <= take_wr;
      rd_wait_q <= take_rd;
    end
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= spv_pkg::ZERO_RST;
    end else if (rd_wait_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // port default vlan tag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vlan_q <= spv_pkg::VLAN_RST;
    end else if (wr_vlan) begin
      vlan_q <= masked(hwdata, spv_pkg::VLAN_MASK);
    end
  end

  // transmit header priority map
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txmap_q <= spv_pkg::TXMAP_RST;
    end else if (wr_txmap) begin
      txmap_q <= masked(hwdata, spv_pkg::TXMAP_MASK);
    end
  end

  // station address, low word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sa_lo_q <= spv_pkg::ZERO_RST;
    end else if (wr_sa_lo) begin
      sa_lo_q <= masked(hwdata, spv_pkg::SA_LO_MASK);
    end
  end

  // station address, high word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sa_hi_q <= spv_pkg::ZERO_RST;
    end else if (wr_sa_hi) begin
      sa_hi_q <= masked(hwdata, spv_pkg::SA_HI_MASK);
    end
  end

  // time-sync control; stored under the mask of the variant in force
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= spv_pkg::ZERO_RST;
    end else if (wr_ctl) begin
      ctl_q <= masked(hwdata, ctl_mask);
    end
  end

  // ethertype match values, first in the low half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      etype_q <= spv_pkg::ZERO_RST;
    end else if (wr_etype) begin
      etype_q <= masked(hwdata, spv_pkg::ETYPE_MASK);
    end
  end

  // variant select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= spv_pkg::ZERO_RST;
    end else if (wr_mode) begin
      mode_q <= masked(hwdata, spv_pkg::MODE_MASK);
    end
  end

  // next values of the lookup and decision results
  wire logic [2:0] txq_d = map_lookup(txmap_q, tx_hdr_prio);
  wire logic tsa_d =
    ts_frame.valid & ts_decide(ctl_rd, variant_two, etype_q, ts_frame);

  // lookup strobe, one cycle behind the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txv_q <= 1'b0;
    end else begin
      txv_q <= tx_hdr_valid;
    end
  end

  // transmit priority remap, held until the next lookup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txq_q <= 3'h0;
    end else if (tx_hdr_valid) begin
      txq_q <= txq_d;
    end
  end

  // time-sync result strobe, one cycle behind the frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsv_q <= 1'b0;
    end else begin
      tsv_q <= ts_frame.valid;
    end
  end

  // time-sync decision, one cycle latency; masked control keeps stale bits out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsa_q <= 1'b0;
    end else begin
      tsa_q <= tsa_d;
    end
  end

  // lookup and decision outputs from flops
  assign tx_queue_prio = txq_q[1:0];
  assign tx_queue_valid = txv_q;
  assign ts_result_valid = tsv_q;
  assign ts_accept = tsa_q;

  // default tag fields straight from the vlan register
  assign port_vlan.port_default_priority = vlan_q[spv_pkg::VLAN_PRI_LSB +: 3];
  assign port_vlan.port_default_canonical_bit = vlan_q[spv_pkg::VLAN_CFI_BIT];
  assign port_vlan.port_default_vlan_id = vlan_q[spv_pkg::VLAN_VID_LSB +: 12];

  // address bytes; byte k of the address sits at station_addr[8k+7:8k]
  wire logic [7:0] station_addr_byte_zero = sa_lo_q[15:8];
  wire logic [7:0] station_addr_byte_one = sa_lo_q[7:0];
  wire logic [7:0] station_addr_byte_two = sa_hi_q[31:24];
  wire logic [7:0] station_addr_byte_three = sa_hi_q[23:16];
  wire logic [7:0] station_addr_byte_four = sa_hi_q[15:8];
  wire logic [7:0] station_addr_byte_five = sa_hi_q[7:0];
  assign station_addr = {station_addr_byte_five, station_addr_byte_four, station_addr_byte_three,
                         station_addr_byte_two, station_addr_byte_one, station_addr_byte_zero};

endmodule : spv_regs

//--- spv_regs_fix_note.sv
// spare source unit with no logic; the register bank holds all of it

//--- spv_regs_assertions.sv
// port-level assertion checker for the spv register bank
module spv_regs_chk (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic tx_hdr_valid, // lookup strobe
  input wire logic tx_queue_valid, // lookup result strobe
  input wire spv_pkg::spv_frame_t ts_frame, // candidate frame
  input wire logic ts_result_valid, // result strobe
  input wire logic ts_accept, // frame accepted
  input wire spv_pkg::spv_vlan_t port_vlan, // default tag
  input wire logic [47:0] station_addr // source address
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_dp_q; // a taken write is in its data phase
  logic any_wr_q; // some write was taken since reset
  wire take = hsel & htrans[1] & hready;
  // write tracking; the register update lands at the edge that ends the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_q <= 1'b0;
      any_wr_q <= 1'b0;
    end else begin
      wr_dp_q <= take & hwrite;
      any_wr_q <= any_wr_q | (take & hwrite);
    end
  end
  chk_map_strobe: assert property (tx_hdr_valid |=> tx_queue_valid)
    else $error("lookup result missing");
  chk_map_quiet: assert property (!tx_hdr_valid |=> !tx_queue_valid)
    else $error("lookup result without request");
  chk_ts_strobe: assert property (ts_frame.valid |=> ts_result_valid)
    else $error("time-sync result missing");
  chk_ts_gate: assert property (!ts_result_valid |-> !ts_accept)
    else $error("accept without result");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_cfg_hold: assert property (!wr_dp_q |=> $stable(port_vlan) && $stable(station_addr))
    else $error("config outputs moved without a write");
  chk_idle_reset: assert property (!any_wr_q |-> !ts_accept)
    else $error("time-sync accepted before any enable");
  cov_read: cover property (take && !hwrite ##2 hreadyout);
  cov_accept: cover property (ts_accept);
  cov_map: cover property (tx_hdr_valid ##1 tx_queue_valid);
endmodule : spv_regs_chk

bind spv_regs spv_regs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .tx_hdr_valid(tx_hdr_valid), .tx_queue_valid(tx_queue_valid), .ts_frame(ts_frame),
  .ts_result_valid(ts_result_valid), .ts_accept(ts_accept), .port_vlan(port_vlan),
  .station_addr(station_addr));

//--- test_switch_port_vlan_prio_ptp_regs.sv
// self-checking bench for the spv register bank
module test_switch_port_vlan_prio_ptp_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_hdr_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'b00, tx_queue_prio;
  logic [2:0] hsize = 3'b010, tx_hdr_prio = 3'h0;
  logic hreadyout, hresp, tx_queue_valid, ts_result_valid, ts_accept;
  spv_pkg::spv_frame_t ts_frame = '0;
  spv_pkg::spv_vlan_t port_vlan;
  logic [47:0] station_addr;
  logic [31:0] mdl [8] = '{1: 32'h33221001, default: 32'h0}; // model registers by word
  spv_pkg::spv_encap_t encs [5] = '{spv_pkg::SPV_ENC_RAW, spv_pkg::SPV_ENC_VLAN1,
    spv_pkg::SPV_ENC_VLAN2, spv_pkg::SPV_ENC_IPV4, spv_pkg::SPV_ENC_IPV6};
  integer seed = 32'h31fced90;
  int num_errors = 0, checked = 0, cyc = 0;
  always #10 hclk = ~hclk;
  spv_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_hdr_prio(tx_hdr_prio),
    .tx_hdr_valid(tx_hdr_valid), .tx_queue_prio(tx_queue_prio),
    .tx_queue_valid(tx_queue_valid), .ts_frame(ts_frame), .ts_result_valid(ts_result_valid),
    .ts_accept(ts_accept), .port_vlan(port_vlan), .station_addr(station_addr));
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // readable bits of each word; control bits follow the selected variant
  function automatic logic [31:0] msk(input int i);
    case (i)
      0, 2: return 32'h0000ffff;
      1: return 32'h77777777;
      3, 5: return 32'hffffffff;
      4: return mdl[6][0] ? 32'hffff07ff : 32'hffff0077;
      6: return 32'h1;
      default: return 32'h0;
    endcase
  endfunction : msk
  // one single ahb-lite transfer; each phase holds until hready is high at a rising edge
  task automatic bus(input logic w, input int i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(i * 4);
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (w) mdl[i] = d;
  endtask : bus
  task automatic rdchk(input int i);
    bus(1'b0, i, 32'h0);
    cmp({hresp, rd}, {1'b0, mdl[i] & msk(i)});
  endtask : rdchk
  // expected acceptance of one candidate frame
  function automatic logic acc(input spv_pkg::spv_frame_t f);
    logic [31:0] c;
    logic md, t, g, eq, a;
    c = mdl[4] & msk(4);
    md = mdl[6][0];
    t = f.is_tx;
    g = t ? c[4] : c[0];
    eq = f.ethertype == mdl[5][15:0] | md & c[8] & f.ethertype == mdl[5][31:16];
    if (!md) eq = eq & g;
    case (f.encap)
      spv_pkg::SPV_ENC_RAW: a = eq & g;
      spv_pkg::SPV_ENC_VLAN1: a = eq & (t ? c[5] : c[1]);
      spv_pkg::SPV_ENC_VLAN2: a = eq & (t ? !md & c[6] : c[2]);
      spv_pkg::SPV_ENC_IPV4: a = md & (t ? c[6] : c[3]);
      default: a = md & (t ? c[10] : c[9]);
    endcase
    return a & c[16 + f.msg_type];
  endfunction : acc
  // back-to-back lookups and frames, each result checked one cycle later
  task automatic traffic();
    logic [31:0] r;
    logic [2:0] pp;
    spv_pkg::spv_frame_t pf, nf;
    for (int k = 0; k <= 40; k++) begin
      @(posedge hclk);
      r = $random(seed);
      nf = {k < 40, r[4], encs[r[7:5] % 5], r[13:12] == 2'b00 ? mdl[5][15:0] :
        r[13:12] == 2'b01 ? mdl[5][31:16] : r[31:16], r[11:8]};
      tx_hdr_prio <= r[2:0];
      tx_hdr_valid <= k < 40;
      ts_frame <= nf;
      #1;
      if (k > 0) cmp({tx_queue_valid, tx_queue_prio}, {1'b1, mdl[1][4 * pp +: 2]});
      if (k > 0) cmp({ts_result_valid, ts_accept}, {1'b1, acc(pf)});
      pp = r[2:0];
      pf = nf;
    end
  endtask : traffic
  // reset values, reserved bits, then random configurations in both variants
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(i);
    cmp({port_vlan, station_addr}, 64'h0);
    traffic();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, i, 32'hffffffff);
      rdchk(i);
    end
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, 6, 32'(r % 2));
      for (int i = 0; i < 6; i++) bus(1'b1, i, $random(seed));
      rdchk(4);
      cmp({port_vlan, station_addr}, {mdl[0][15:0], mdl[3][7:0], mdl[3][15:8],
        mdl[3][23:16], mdl[3][31:24], mdl[2][7:0], mdl[2][15:8]});
      traffic();
    end
    tally_and_finish();
  end
endmodule : test_switch_port_vlan_prio_ptp_regs
